// file: pse_wd_pkg.sv
// pse_wd_pkg: register map, fields, reset values and carriers for the
// watchdog and global control block.
// assumes the serial interface engine runs on core_clk.
package pse_wd_pkg;

   // register offsets
   localparam logic [7:0] ADDR_PORT_MODE = 8'h12;
   localparam logic [7:0] ADDR_GLOBAL_PUSHBUTTONS = 8'h1a;
   localparam logic [7:0] ADDR_PART_IDENTIFICATION = 8'h1b;
   localparam logic [7:0] ADDR_HW_TAKEOVER_FLAGS = 8'h1c;
   localparam logic [7:0] ADDR_WATCHDOG_COUNT = 8'h1e;
   localparam logic [7:0] ADDR_WATCHDOG_SWITCH_CONFIG = 8'h1f;
   localparam logic [7:0] ADDR_DETECTION_PROGRAM = 8'h23;
   localparam logic [7:0] ADDR_HIGH_POWER_RESERVED = 8'h24;
   localparam logic [7:0] ADDR_SPARE_RESERVED = 8'h25;

   // pushbutton fields
   localparam int BIT_INTERRUPT_CLEAR_ALL = 7;
   localparam int BIT_CHIP_SOFT_RESET = 4;
   localparam int LSB_PORT_RESET = 0;

   // switch config fields
   localparam int BIT_WATCHDOG_ENABLE = 7;
   localparam int BIT_TAKEOVER_IRQ_ENABLE = 6;
   localparam int BIT_SWITCH_SPARE = 4;
   localparam int LSB_EXPIRY_BEHAVIOR = 0;

   // program register fields
   localparam int BIT_BIG_CAP_DETECT_ENABLE = 5;
   localparam int BIT_DETECTION_BYPASS_ALLOW = 4;
   localparam int BIT_OSCILLATOR_FAULT_FLAG_IGNORE = 3;
   localparam int LSB_AC_DISCONNECT_THRESHOLD = 0;

   // reset values
   localparam logic [7:0] RST_HW_TAKEOVER_FLAGS = 8'h00;
   localparam logic [7:0] RST_WATCHDOG_COUNT = 8'h00;
   localparam logic [7:0] RST_WATCHDOG_SWITCH_CONFIG = 8'h00;
   localparam logic [7:0] RST_DETECTION_PROGRAM = 8'h04;

   // port mode codes driven into the mode register on expiry
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h3;

   // watchdog tick
   localparam int CLK_PERIOD_NS = 8;
   localparam int WD_TICK_MS = 164;
   localparam int WD_TICK_CYCLES = WD_TICK_MS * 1000000 / CLK_PERIOD_NS;

   // arbitrary identification values, not tied to any real part
   localparam logic [4:0] PART_IDENTIFIER = 5'h15;
   localparam logic [2:0] REVISION_FIELD = 3'h1;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic big_cap_detect_enable;
      logic detection_bypass_allow;
      logic oscillator_fault_flag_ignore;
      logic [2:0] ac_disconnect_threshold;
   } det_cfg_t;

   typedef enum logic [1:0] {
      WD_SOFT = 2'b01,
      WD_HARD = 2'b10
   } wd_state_t;

endpackage

// file: pse_watchdog_and_global_control.sv
// pse_watchdog_and_global_control: global pushbuttons, identification,
// watchdog with hardware takeover, and the detection program register.
// assumes the serial interface engine presents one-cycle register
// requests on core_clk and takes read data one cycle later.
//
// Operation
// - bit 7 pushbutton clears interrupts and events
// - bit 4 pushbutton resets whole register map
// - bits 3:0 pushbutton soft-reset ports 4..1
// - port reset: power off, clear that port
// - pushbutton bits self-clear after action
// - read-only id: part id and revision
// - takeover flag set on expiry takeover
// - takeover flag set on refused power-on
// - flags in 1Ch bits 3:0, clear on read
// - takeover flag register resets to zero
// - switch bit 7 enables the watchdog
// - counter decrements once every 164 ms
// - expiry enters hardware-controlled mode for all ports at once
// - expiry writes mode 00 or 11
// - hardware mode ignores power-on requests
// - hardware mode refuses operating mode changes
// - takeover irq when enabled and flag set
// - count and switch registers reset zero
// - bit 5 enables large capacitor detection
// - three-bit ac disconnect threshold field
// - bit 4 allows power without detection
// - program register resets to 04h
module pse_watchdog_and_global_control #(
   parameter int TICK_CYCLES = pse_wd_pkg::WD_TICK_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port from the serial interface engine
   input wire pse_wd_pkg::reg_req_t reg_req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // requests from the port-control logic; oscillator fault flag from the analog side
   input wire logic [3:0] power_on_req,
   input wire logic mode_change_req,
   input wire logic [3:0] detection_skipped,
   input wire logic oscillator_fault_flag,
   // grants and actions toward the port-control logic; det_cfg toward the analog side
   output logic [3:0] power_on_grant,
   output logic mode_change_grant,
   output logic [3:0] bypass_power_block,
   output logic osc_fault_effective,
   output logic hw_control,
   output logic port_mode_force,
   output logic [7:0] port_mode_value,
   output logic interrupt_clear_all,
   output logic chip_soft_reset,
   output logic [3:0] port_soft_reset,
   output logic takeover_irq,
   output pse_wd_pkg::det_cfg_t det_cfg
);

   logic [7:0] hw_takeover_flag;
   logic [7:0] watchdog_count;
   logic [7:0] watchdog_switch_config;
   logic [7:0] detection_program;
   logic [24:0] tick_cnt;
   logic tick;
   logic map_rst;
   logic osc_meta;
   logic osc_sync;
   pse_wd_pkg::wd_state_t wd_state;
   logic [3:0] next_set;
   logic expire;
   logic wr_gp;
   logic wd_en;

   // a pushbutton chip reset returns the map one cycle after the write
   assign map_rst = srst | chip_soft_reset;
   assign wd_en = watchdog_switch_config[pse_wd_pkg::BIT_WATCHDOG_ENABLE];
   assign wr_gp = reg_req.wr &&
      reg_req.addr == pse_wd_pkg::ADDR_GLOBAL_PUSHBUTTONS;
   assign expire = (wd_state == pse_wd_pkg::WD_SOFT) && wd_en &&
      watchdog_count == 8'h00;

   function automatic logic wr_hit(input pse_wd_pkg::reg_req_t r,
                                   input logic [7:0] a);
      wr_hit = r.wr && r.addr == a;
   endfunction

   function automatic logic rd_hit(input pse_wd_pkg::reg_req_t r,
                                   input logic [7:0] a);
      rd_hit = r.rd && r.addr == a;
   endfunction

   // pushbuttons: one-cycle pulses, nothing stored so bits read back zero
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         interrupt_clear_all <= 1'b0;
         chip_soft_reset <= 1'b0;
         port_soft_reset <= 4'h0;
      end
      else
      begin
         interrupt_clear_all <= wr_gp &&
            reg_req.wdata[pse_wd_pkg::BIT_INTERRUPT_CLEAR_ALL];
         chip_soft_reset <= wr_gp &&
            reg_req.wdata[pse_wd_pkg::BIT_CHIP_SOFT_RESET];
         port_soft_reset <= wr_gp ?
            reg_req.wdata[pse_wd_pkg::LSB_PORT_RESET +: 4] : 4'h0;
      end
   end

   // watchdog tick prescaler, runs only while enabled
   always_ff @(posedge core_clk)
   begin
      if (map_rst || !wd_en)
      begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end
      else if (tick_cnt == 25'(TICK_CYCLES - 1))
      begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 25'd1;
         tick <= 1'b0;
      end
   end

   // watchdog count: host write wins over a tick in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         watchdog_count <= pse_wd_pkg::RST_WATCHDOG_COUNT;
      else if (wr_hit(reg_req, pse_wd_pkg::ADDR_WATCHDOG_COUNT))
         watchdog_count <= reg_req.wdata;
      else if (tick && wd_en && watchdog_count != 8'h00)
         watchdog_count <= watchdog_count - 8'd1;
   end

   // reserved bit 5 is not stored and reads back zero
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         watchdog_switch_config <= pse_wd_pkg::RST_WATCHDOG_SWITCH_CONFIG;
      else if (wr_hit(reg_req, pse_wd_pkg::ADDR_WATCHDOG_SWITCH_CONFIG))
         watchdog_switch_config <= reg_req.wdata & 8'hdf;
   end

   // bits 7:6 are reserved and read back zero
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         detection_program <= pse_wd_pkg::RST_DETECTION_PROGRAM;
      else if (wr_hit(reg_req, pse_wd_pkg::ADDR_DETECTION_PROGRAM))
         detection_program <= reg_req.wdata & 8'h3f;
   end

   // hardware control is left only by a map reset, by disabling the watchdog or by
   // reloading a nonzero count; a late reload does not undo the takeover
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         wd_state <= pse_wd_pkg::WD_SOFT;
      else
         unique case (wd_state)
            pse_wd_pkg::WD_SOFT:
               if (expire)
                  wd_state <= pse_wd_pkg::WD_HARD;
            pse_wd_pkg::WD_HARD:
               if (!wd_en || (wr_hit(reg_req,
                   pse_wd_pkg::ADDR_WATCHDOG_COUNT) &&
                   reg_req.wdata != 8'h00))
                  wd_state <= pse_wd_pkg::WD_SOFT;
            default:
               wd_state <= pse_wd_pkg::WD_SOFT;
         endcase
   end

   // mode force on expiry, one 2-bit field per port
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
      begin
         port_mode_force <= 1'b0;
         port_mode_value <= 8'h00;
      end
      else
      begin
         port_mode_force <= expire;
         for (int p = 0; p < 4; p++)
            port_mode_value[2*p +: 2] <=
               watchdog_switch_config[pse_wd_pkg::LSB_EXPIRY_BEHAVIOR + p] ?
               pse_wd_pkg::MODE_AUTO : pse_wd_pkg::MODE_SHUTDOWN;
      end
   end

   // hardware control follows the state machine, raised with the expiry
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         hw_control <= 1'b0;
      else
         hw_control <= (wd_state == pse_wd_pkg::WD_HARD) || expire;
   end

   // request gating while the hardware holds control
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
      begin
         power_on_grant <= 4'h0;
         mode_change_grant <= 1'b0;
      end
      else
      begin
         power_on_grant <= hw_control ? 4'h0 : power_on_req;
         mode_change_grant <= mode_change_req && !hw_control;
      end
   end

   always_comb
   begin
      next_set = 4'h0;
      if (expire)
         next_set = 4'hf;
      if (hw_control)
         next_set = next_set | power_on_req;
   end

   // takeover flags: a set in the read cycle survives the clear
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         hw_takeover_flag <= pse_wd_pkg::RST_HW_TAKEOVER_FLAGS;
      else if (rd_hit(reg_req, pse_wd_pkg::ADDR_HW_TAKEOVER_FLAGS))
         hw_takeover_flag <= {4'h0, next_set};
      else
         hw_takeover_flag <= hw_takeover_flag | {4'h0, next_set};
   end

   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         takeover_irq <= 1'b0;
      else
         takeover_irq <= watchdog_switch_config
            [pse_wd_pkg::BIT_TAKEOVER_IRQ_ENABLE] &&
            (hw_takeover_flag[3:0] != 4'h0 || next_set != 4'h0);
   end

   // oscillator fault comes from the analog side: synchronise first
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
      end
      else
      begin
         osc_meta <= oscillator_fault_flag;
         osc_sync <= osc_meta;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         osc_fault_effective <= 1'b0;
      else
         osc_fault_effective <= osc_sync &&
            !detection_program[pse_wd_pkg::BIT_OSCILLATOR_FAULT_FLAG_IGNORE];
   end

   // auto-mode power-on block for ports whose detection was skipped
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         bypass_power_block <= 4'h0;
      else
         bypass_power_block <= detection_program
            [pse_wd_pkg::BIT_DETECTION_BYPASS_ALLOW] ?
            4'h0 : detection_skipped;
   end

   // program register fields as the analog side sees them
   function automatic pse_wd_pkg::det_cfg_t det_fields(
      input logic [7:0] v);
      pse_wd_pkg::det_cfg_t c;
      c.big_cap_detect_enable = v[pse_wd_pkg::BIT_BIG_CAP_DETECT_ENABLE];
      c.detection_bypass_allow = v[pse_wd_pkg::BIT_DETECTION_BYPASS_ALLOW];
      c.oscillator_fault_flag_ignore = v[pse_wd_pkg::BIT_OSCILLATOR_FAULT_FLAG_IGNORE];
      c.ac_disconnect_threshold =
         v[pse_wd_pkg::LSB_AC_DISCONNECT_THRESHOLD +: 3];
      return c;
   endfunction

   // the copy leaves reset at the register's reset value, so the analog
   // side never sees a zero threshold while the map is being reset
   always_ff @(posedge core_clk)
   begin
      if (map_rst)
         det_cfg <= det_fields(pse_wd_pkg::RST_DETECTION_PROGRAM);
      else
         det_cfg <= det_fields(detection_program);
   end

   // read data one cycle after the request; unmapped reads give zero
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= reg_req.rd;
         rd_data <= 8'h00;
         if (reg_req.rd)
            unique case (reg_req.addr)
               pse_wd_pkg::ADDR_PART_IDENTIFICATION:
                  rd_data <= {pse_wd_pkg::PART_IDENTIFIER,
                              pse_wd_pkg::REVISION_FIELD};
               pse_wd_pkg::ADDR_HW_TAKEOVER_FLAGS:
                  rd_data <= hw_takeover_flag;
               pse_wd_pkg::ADDR_WATCHDOG_COUNT:
                  rd_data <= watchdog_count;
               pse_wd_pkg::ADDR_WATCHDOG_SWITCH_CONFIG:
                  rd_data <= watchdog_switch_config;
               pse_wd_pkg::ADDR_DETECTION_PROGRAM:
                  rd_data <= detection_program;
               default:
                  rd_data <= 8'h00;
            endcase
      end
   end

endmodule // pse_watchdog_and_global_control

// file: pse_wd_sva.sv
// pse_wd_sva: port-level checks for the watchdog and global control block.
// assumes it is bound to the top module and sees its ports by name.
module pse_wd_sva #(
   parameter int TICK_CYCLES = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire pse_wd_pkg::reg_req_t reg_req,
   input wire logic [7:0] rd_data,
   // port control
   input wire logic [3:0] power_on_req,
   input wire logic [3:0] power_on_grant,
   input wire logic mode_change_grant,
   input wire logic hw_control,
   input wire logic port_mode_force,
   input wire logic interrupt_clear_all,
   input wire logic chip_soft_reset,
   input wire logic [3:0] port_soft_reset,
   input wire pse_wd_pkg::det_cfg_t det_cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   wire pb = reg_req.wr && reg_req.addr == 8'h1a;
   wire idr = reg_req.rd && reg_req.addr == 8'h1b;
   AST_PB_CLEAR: assert property (pb && reg_req.wdata[7] |=> interrupt_clear_all)
      else $error("clear-all pulse missing");
   AST_PB_CHIP: assert property (pb && reg_req.wdata[4] |=> chip_soft_reset)
      else $error("chip reset pulse missing");
   AST_PB_PORT: assert property (
      pb |=> port_soft_reset == $past(reg_req.wdata[3:0]))
      else $error("port reset pulses wrong");
   AST_PB_SELF: assert property (
      !pb |=> !chip_soft_reset && !interrupt_clear_all && port_soft_reset == 4'h0)
      else $error("pushbutton output did not return to zero");
   AST_ID_READ: assert property (
      idr |=> rd_data == {pse_wd_pkg::PART_IDENTIFIER, pse_wd_pkg::REVISION_FIELD})
      else $error("identification read wrong");
   AST_HW_BLOCK: assert property (
      hw_control |=> power_on_grant == 4'h0 && !mode_change_grant)
      else $error("grant given under hardware control");
   AST_GRANT: assert property (
      power_on_req != 4'h0 && !hw_control |=> power_on_grant == $past(power_on_req))
      else $error("power-on grant wrong in software control");
   AST_FORCE: assert property ($rose(hw_control) |-> port_mode_force)
      else $error("mode not forced on takeover");
   AST_RST_CFG: assert property ($past(srst) |-> det_cfg == 6'h04)
      else $error("program register reset value wrong");
   cover property (port_mode_force);
   cover property (chip_soft_reset);
   cover property (hw_control && power_on_req != 4'h0);
endmodule // pse_wd_sva

bind pse_watchdog_and_global_control pse_wd_sva #(
   .TICK_CYCLES(TICK_CYCLES)
) u_pse_wd_sva (
   .core_clk, .srst, .reg_req, .rd_data, .power_on_req, .power_on_grant,
   .mode_change_grant, .hw_control, .port_mode_force, .interrupt_clear_all,
   .chip_soft_reset, .port_soft_reset, .det_cfg
);

// file: pse_host_model.sv
// pse_host_model: host side of the register port, one request at a time.
// assumes its tasks are called from a single bench process.
module pse_host_model (
   // clock
   input wire logic core_clk,
   // register port toward the block
   output pse_wd_pkg::reg_req_t reg_req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_req = '0;
   end
   // released lines show the inverse so stale values never pass for data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic v);
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      #1;
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      d = rd_data;
      v = rd_valid;
   endtask
   // keeps the count nonzero, faster than two ticks of the shortened watchdog
   task automatic feed(input int k);
      repeat (k) wr(8'h1e, 8'h02);
   endtask
endmodule // pse_host_model

// file: test_pse_watchdog_and_global_control.sv
// test_pse_watchdog_and_global_control: directed register-level tests.
// assumes a watchdog tick shortened to 16 cycles of core_clk.
module test_pse_watchdog_and_global_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = {pse_wd_pkg::PART_IDENTIFIER,
      pse_wd_pkg::REVISION_FIELD};
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   pse_wd_pkg::reg_req_t reg_req;
   pse_wd_pkg::det_cfg_t det_cfg;
   logic [7:0] rd_data, port_mode_value, d;
   logic rd_valid, mode_change_grant, osc_fault_effective, hw_control, v;
   logic port_mode_force, interrupt_clear_all, chip_soft_reset, takeover_irq;
   logic mode_change_req = 1'b0;
   logic oscillator_fault_flag = 1'b1;
   logic [3:0] power_on_grant, bypass_power_block, port_soft_reset;
   logic [3:0] power_on_req = 4'h0;
   logic [3:0] detection_skipped = 4'hf;
   int n_errors = 0;
   int comparisons = 0;
   int n;
   wire [7:0] pbo = {interrupt_clear_all, 2'h0, chip_soft_reset,
      port_soft_reset};
   wire [7:0] gnt = {3'h0, mode_change_grant, power_on_grant};
   always #4 core_clk = ~core_clk;
   pse_watchdog_and_global_control #(
      .TICK_CYCLES(16)
   ) u_pse_watchdog_and_global_control (
      .core_clk, .srst, .reg_req, .rd_data, .rd_valid, .power_on_req,
      .mode_change_req, .detection_skipped, .oscillator_fault_flag,
      .power_on_grant, .mode_change_grant, .bypass_power_block,
      .osc_fault_effective, .hw_control, .port_mode_force, .port_mode_value,
      .interrupt_clear_all, .chip_soft_reset, .port_soft_reset,
      .takeover_irq, .det_cfg
   );
   pse_host_model u_pse_host_model (
      .core_clk, .reg_req, .rd_data, .rd_valid
   );
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] dat);
      u_pse_host_model.wr(a, dat);
   endtask
   task automatic r(input string what, input logic [7:0] a,
      input logic [7:0] exp);
      u_pse_host_model.rd(a, d, v);
      chk("rd_valid", 8'h01, {7'h0, v});
      chk(what, exp, d);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // a missing takeover counts as a mismatch and ends the run
   task automatic wait_hw(input int lim);
      n = 0;
      while (hw_control !== 1'b1 && n < lim)
      begin
         tick(1);
         n++;
      end
      if (n >= lim)
      begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic pulse_req(input logic [3:0] p);
      power_on_req = p;
      mode_change_req = 1'b1;
      tick(1);
      power_on_req = 4'h0;
      mode_change_req = 1'b0;
   endtask
   initial
   begin
      tick(6);
      srst = 1'b0;
      r("flags", 8'h1c, 8'h00);
      r("count", 8'h1e, 8'h00);
      r("switch", 8'h1f, 8'h00);
      r("program", 8'h23, 8'h04);
      w(8'h1b, 8'h00);
      r("id", 8'h1b, ID);
      r("reserved", 8'h24, 8'h00);
      r("unmapped", 8'h40, 8'h00);
      w(8'h23, 8'hff);
      r("program", 8'h23, 8'h3f);
      chk("det_cfg", 8'h3f, {2'h0, det_cfg});
      chk("bypass", 8'h00, {4'h0, bypass_power_block});
      chk("osc", 8'h00, {7'h0, osc_fault_effective});
      w(8'h23, 8'h00);
      tick(2);
      chk("det_cfg", 8'h00, {2'h0, det_cfg});
      chk("bypass", 8'h0f, {4'h0, bypass_power_block});
      chk("osc", 8'h01, {7'h0, osc_fault_effective});
      pulse_req(4'h5);
      chk("grants", 8'h15, gnt);
      w(8'h1a, 8'h8a);
      chk("pushbuttons", 8'h8a, pbo);
      tick(1);
      chk("pushbuttons", 8'h00, pbo);
      w(8'h1f, 8'hc5);
      wait_hw(4);
      chk("mode value", 8'h33, port_mode_value);
      chk("force irq", 8'h03, {6'h0, port_mode_force, takeover_irq});
      r("flags", 8'h1c, 8'h0f);
      r("flags", 8'h1c, 8'h00);
      chk("irq", 8'h00, {7'h0, takeover_irq});
      r("count", 8'h1e, 8'h00);
      pulse_req(4'h2);
      chk("grants", 8'h00, gnt);
      r("flags", 8'h1c, 8'h02);
      u_pse_host_model.feed(12);
      chk("hw_control", 8'h00, {7'h0, hw_control});
      wait_hw(60);
      chk("expiry time", 8'h01, {7'h0, n > 16 && n <= 34});
      w(8'h1f, 8'h00);
      w(8'h1e, 8'h05);
      tick(40);
      r("count", 8'h1e, 8'h05);
      chk("hw_control", 8'h00, {7'h0, hw_control});
      w(8'h1a, 8'h10);
      chk("pushbuttons", 8'h10, pbo);
      tick(2);
      r("count", 8'h1e, 8'h00);
      r("program", 8'h23, 8'h04);
      chk("det_cfg", 8'h04, {2'h0, det_cfg});
      tally_and_finish();
   end
endmodule // test_pse_watchdog_and_global_control
